// [shared/omcs_pkg.sv]
// package of constants and types for the optical module control/status block
`default_nettype none
package omcs_pkg;
  // -------------------------------------------------
  // register map
  // -------------------------------------------------
  localparam logic [7:0] OMCS_CSB_ADDR = 8'h6e;
  localparam int OMCS_BIT_TXOFF_STATE = 7;
  localparam int OMCS_BIT_TXOFF_SW = 6;
  localparam int OMCS_BIT_BW_STATE = 4;
  localparam int OMCS_BIT_BW_SW = 3;
  localparam int OMCS_BIT_FAULT = 2;
  localparam int OMCS_BIT_LOST = 1;
  localparam logic [7:0] OMCS_SW_MASK = 8'h48;
  localparam logic [7:0] OMCS_CSB_RESET = 8'h00;
  // -------------------------------------------------
  // timing
  // -------------------------------------------------
  localparam int OMCS_CLK_HZ = 20_000_000;
  localparam int OMCS_TXOFF_GAP_MS = 10;
  localparam int OMCS_TXOFF_GAP_CYC = OMCS_CLK_HZ / 1000 * OMCS_TXOFF_GAP_MS;
  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } omcs_req_t;
  // laser fault latch states
  typedef enum logic [1:0] {
    OMCS_F_OK = 2'b00,
    OMCS_F_LATCHED = 2'b01,
    OMCS_F_OFF_SEEN = 2'b10
  } omcs_fstate_t;
endpackage : omcs_pkg
`default_nettype wire

// [rtl/omcs_sync.sv]
// two-flop synchroniser bank for sideband pins
`default_nettype none
module omcs_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  // -------------------------------------------------
  // per-bit double flop; first stage read by second only
  // -------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (srst) begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
      end else begin
        s1_ff[i] <= d[i];
        s2_ff[i] <= s1_ff[i];
      end
    end
  end
  assign q = s2_ff;
endmodule : omcs_sync
`default_nettype wire

// [rtl/omcs_ctrl.sv]
// control/status logic of the optical module: fault latch, shutdown, bandwidth, lost flag
`default_nettype none
module omcs_ctrl
  import omcs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic TX_OFF_PIN,
  input wire logic BW_SEL_PIN,
  input wire logic LASER_FAULT_IN,
  input wire logic UNSAFE_OUT_IN,
  input wire logic INPUT_LOST_IN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic LASER_EN,
  output logic FAULT_FLAG_OE,
  output logic BW_HIGH,
  output logic OPTICAL_INPUT_LOST
);
  // -------------------------------------------------
  // pin synchronisation
  // -------------------------------------------------
  logic [4:0] pins_s;
  omcs_sync #(.W(5)) u_sync (
    .clk(SYS_CLK),
    .srst(SRST),
    .d({TX_OFF_PIN, BW_SEL_PIN, LASER_FAULT_IN, UNSAFE_OUT_IN, INPUT_LOST_IN}),
    .q(pins_s)
  );
  wire tx_off_pin_s = pins_s[4];
  wire bw_pin_s = pins_s[3];
  wire fault_src_s = pins_s[2];
  wire unsafe_s = pins_s[1];
  wire lost_s = pins_s[0];

  // -------------------------------------------------
  // register access decode
  // -------------------------------------------------
  omcs_req_t req;
  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  wire hit = (req.addr == OMCS_CSB_ADDR);
  wire wr_hit = req.wr && hit;
  logic txoff_sw_ff;
  logic bw_sw_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic lost_ff;
  logic bw_ff;
  omcs_fstate_t fstate_ff;
  omcs_fstate_t nxt_fstate;
  logic txoff_d_ff;

  // effective controls
  wire txoff_eff = tx_off_pin_s | txoff_sw_ff;
  wire bw_eff = bw_pin_s | bw_sw_ff;
  wire fault_latched = (fstate_ff != OMCS_F_OK);
  // a clear step starts only on a fresh rise; a level held since before the fault does not count
  wire txoff_rise = txoff_eff && !txoff_d_ff;

  // software bits; only bits 6 and 3 are writable
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      txoff_sw_ff <= 1'b0;
      bw_sw_ff <= 1'b0;
    end else if (wr_hit) begin
      txoff_sw_ff <= req.wdata[OMCS_BIT_TXOFF_SW];
      bw_sw_ff <= req.wdata[OMCS_BIT_BW_SW];
    end
  end

  // status byte image; reserved bits 5 and 0 read zero
  wire [7:0] csb_img = {txoff_eff, txoff_sw_ff, 1'b0, bw_eff, bw_sw_ff,
                        fault_latched, lost_s, 1'b0};

  // read answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_ff <= OMCS_CSB_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req.rd;
      rdata_ff <= (req.rd && hit) ? csb_img : 8'h00;
    end
  end
  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;

  // -------------------------------------------------
  // laser fault latch
  // -------------------------------------------------
  // previous effective transmit-off, for rise detection
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      txoff_d_ff <= 1'b0;
    end else begin
      txoff_d_ff <= txoff_eff;
    end
  end

  // fault source wins over any clear step, so a fresh fault is never lost
  always_comb begin
    nxt_fstate = fstate_ff;
    unique case (fstate_ff)
      OMCS_F_OK: begin
        if (fault_src_s) nxt_fstate = OMCS_F_LATCHED;
      end
      OMCS_F_LATCHED: begin
        if (txoff_rise && !fault_src_s) nxt_fstate = OMCS_F_OFF_SEEN;
      end
      OMCS_F_OFF_SEEN: begin
        if (fault_src_s) nxt_fstate = OMCS_F_LATCHED;
        else if (!txoff_eff) nxt_fstate = OMCS_F_OK;
      end
      default: nxt_fstate = OMCS_F_LATCHED;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      fstate_ff <= OMCS_F_OK;
    end else begin
      fstate_ff <= nxt_fstate;
    end
  end

  // -------------------------------------------------
  // outputs
  // -------------------------------------------------
  logic laser_en_ff;
  logic fault_oe_ff;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      laser_en_ff <= 1'b0;
      fault_oe_ff <= 1'b1;
      lost_ff <= 1'b0;
      bw_ff <= 1'b0;
    end else begin
      // any shutdown cause holds the laser dark
      laser_en_ff <= !(txoff_eff || unsafe_s || fault_latched || fault_src_s);
      // open-drain: pull low for normal, release so host pull-up reads high on fault
      fault_oe_ff <= !(fault_latched || fault_src_s);
      lost_ff <= lost_s;
      bw_ff <= bw_eff;
    end
  end
  assign LASER_EN = laser_en_ff;
  assign FAULT_FLAG_OE = fault_oe_ff;
  assign OPTICAL_INPUT_LOST = lost_ff;
  assign BW_HIGH = bw_ff;

  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  property p_fault_kills_laser;
    @(posedge SYS_CLK) disable iff (SRST) fault_src_s |=> !LASER_EN && !FAULT_FLAG_OE;
  endproperty
  a_fault_kills_laser: assert property (p_fault_kills_laser)
    else $error("fault did not disable laser");
  property p_flag_low_normal;
    @(posedge SYS_CLK) disable iff (SRST) (!fault_latched && !fault_src_s) |=> FAULT_FLAG_OE;
  endproperty
  a_flag_low_normal: assert property (p_flag_low_normal)
    else $error("fault flag not low in normal operation");
  property p_latch_holds;
    @(posedge SYS_CLK) disable iff (SRST)
      (fstate_ff == OMCS_F_LATCHED && !txoff_eff) |=> fault_latched;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("fault latch cleared without transmit-off toggle");
  property p_unsafe_off;
    @(posedge SYS_CLK) disable iff (SRST) unsafe_s |=> !LASER_EN;
  endproperty
  a_unsafe_off: assert property (p_unsafe_off)
    else $error("unsafe output did not disable laser");
  property p_bw_follow;
    @(posedge SYS_CLK) disable iff (SRST) 1'b1 |=> BW_HIGH == $past(bw_pin_s | bw_sw_ff);
  endproperty
  a_bw_follow: assert property (p_bw_follow)
    else $error("bandwidth choice not OR of pin and bit");
  property p_txoff_off;
    @(posedge SYS_CLK) disable iff (SRST) tx_off_pin_s |=> !LASER_EN;
  endproperty
  a_txoff_off: assert property (p_txoff_off)
    else $error("transmit-off pin did not shut laser");
  property p_rd_state;
    @(posedge SYS_CLK) disable iff (SRST) (req.rd && hit) |=>
      REG_RVALID && REG_RDATA[OMCS_BIT_TXOFF_STATE] == $past(txoff_eff) &&
      REG_RDATA[OMCS_BIT_FAULT] == $past(fault_latched);
  endproperty
  a_rd_state: assert property (p_rd_state)
    else $error("status read mismatch");
  property p_lost_mirror;
    @(posedge SYS_CLK) disable iff (SRST) (req.rd && hit) |=>
      REG_RDATA[OMCS_BIT_LOST] == $past(lost_s);
  endproperty
  a_lost_mirror: assert property (p_lost_mirror)
    else $error("lost bit mismatch");
  property p_lost_out;
    @(posedge SYS_CLK) disable iff (SRST) lost_s |=> OPTICAL_INPUT_LOST;
  endproperty
  a_lost_out: assert property (p_lost_out)
    else $error("lost output not high");
  // a latched fault may only clear after transmit-off was seen high
  property p_clear_after_off;
    @(posedge SYS_CLK) disable iff (SRST) fault_latched ##1 !fault_latched |-> $past(txoff_eff, 2);
  endproperty
  a_clear_after_off: assert property (p_clear_after_off)
    else $error("fault latch cleared without transmit-off high");
  property p_bw_low;
    @(posedge SYS_CLK) disable iff (SRST) (!bw_pin_s && !bw_sw_ff) |=> !BW_HIGH;
  endproperty
  a_bw_low: assert property (p_bw_low)
    else $error("bandwidth not low with pin and bit clear");
  c_fault: cover property (@(posedge SYS_CLK) disable iff (SRST) fault_src_s ##1 fault_latched);
  c_clear: cover property (@(posedge SYS_CLK) disable iff (SRST)
    fstate_ff == OMCS_F_OFF_SEEN ##1 fstate_ff == OMCS_F_OK);
  c_bw_sw: cover property (@(posedge SYS_CLK) disable iff (SRST) bw_sw_ff && !bw_pin_s);
  c_unsafe: cover property (@(posedge SYS_CLK) disable iff (SRST) unsafe_s ##1 !LASER_EN);
endmodule : omcs_ctrl
`default_nettype wire

// [verification/omcs_host_model.sv]
// host board model: spaced transmit-off driver and fault line pull-up
`default_nettype none
module omcs_host_model
  import omcs_pkg::*;
#(
  parameter int GAP_CYC = OMCS_TXOFF_GAP_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic off_req,
  input wire logic fault_oe,
  output logic tx_off_pin,
  output logic fault_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_cnt;
  // ---------------------------------------------
  // board side of the sideband pins
  // ---------------------------------------------
  // released open-drain line goes to the pull-up level
  assign fault_pin = fault_oe ? 1'b0 : 1'b1;
  // an idle request keeps the pin grounded; early requests wait out the gap
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_off_pin <= 1'b0;
      gap_cnt <= GAP_CYC;
    end else begin
      if (gap_cnt != 0) gap_cnt <= gap_cnt - 1;
      if (!off_req) tx_off_pin <= 1'b0;
      else if (gap_cnt == 0 && !tx_off_pin) begin
        tx_off_pin <= 1'b1;
        gap_cnt <= GAP_CYC;
      end
    end
  end
endmodule : omcs_host_model
`default_nettype wire

// [verification/omcs_ctrl_tb.sv]
// self-checking bench for the optical module control/status logic
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module omcs_ctrl_tb
  import omcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic bw, lost; logic [7:0] wd; logic eb, el, elas; logic [7:0] ecsb;
  } omcs_row_t;
  // pins, software write, then expected bandwidth, lost, laser and byte
  omcs_row_t rows [5] = '{
    '{1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00},
    '{1'b1, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1, 8'h10},
    '{1'b0, 1'b1, 8'h08, 1'b1, 1'b1, 1'b1, 8'h1a},
    '{1'b0, 1'b0, 8'h40, 1'b0, 1'b0, 1'b0, 8'hc0},
    '{1'b1, 1'b1, 8'hff, 1'b1, 1'b1, 1'b0, 8'hda}};
  logic clk = 1'b0, srst = 1'b1, off_req = 1'b0, bw = 1'b0, fault = 1'b0;
  logic unsafe = 1'b0, lost = 1'b0, wr = 1'b0, rd = 1'b0;
  logic rvalid, laser, oe, bwh, olost, tx_off_pin, fault_pin;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, rv;
  int num_errors = 0, compares = 0;
  omcs_ctrl i_dut (.SYS_CLK(clk), .SRST(srst), .TX_OFF_PIN(tx_off_pin), .BW_SEL_PIN(bw),
    .LASER_FAULT_IN(fault), .UNSAFE_OUT_IN(unsafe), .INPUT_LOST_IN(lost), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .LASER_EN(laser), .FAULT_FLAG_OE(oe), .BW_HIGH(bwh), .OPTICAL_INPUT_LOST(olost));
  // short gap keeps the run brief; the real spacing is far longer
  omcs_host_model #(.GAP_CYC(8)) i_host (.clk(clk), .srst(srst), .off_req(off_req),
    .fault_oe(oe), .tx_off_pin(tx_off_pin), .fault_pin(fault_pin));
  // ---------------------------------------------
  // clock, bus tasks, closing
  // ---------------------------------------------
  initial forever #25 clk = ~clk;
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) begin wr = 1'b1; addr = a; wd = d; end
    @(negedge clk) wr = 1'b0;
  endtask : wr_reg
  // answer stands one cycle only, so it is sampled at the next falling edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) begin rd = 1'b1; addr = a; end
    @(negedge clk) rd = 1'b0;
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask : rd_reg
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    #(3000 * 50);
    num_errors++;
    stop_test();
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    `CHK(laser, 1'b0)
    `CHK(oe, 1'b1)
    @(negedge clk) srst = 1'b0;
    repeat (10) @(negedge clk);
    $display("reset test done");
    foreach (rows[i]) begin
      @(negedge clk) begin bw = rows[i].bw; lost = rows[i].lost; end
      wr_reg(OMCS_CSB_ADDR, rows[i].wd);
      repeat (4) @(negedge clk);
      rd_reg(OMCS_CSB_ADDR, rv);
      `CHK(rv, rows[i].ecsb)
      `CHK(bwh, rows[i].eb)
      `CHK(olost, rows[i].el)
      `CHK(laser, rows[i].elas)
    end
    wr_reg(OMCS_CSB_ADDR, 8'h00);
    @(negedge clk) begin bw = 1'b0; lost = 1'b0; end
    $display("table test done");
    // fault latches and outlives its cause
    fault = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(laser, 1'b0)
    `CHK(fault_pin, 1'b1)
    fault = 1'b0;
    repeat (4) @(negedge clk);
    rd_reg(OMCS_CSB_ADDR, rv);
    `CHK(rv, 8'h04)
    off_req = 1'b1;
    repeat (5) @(negedge clk);
    rd_reg(OMCS_CSB_ADDR, rv);
    `CHK(rv, 8'h84)
    off_req = 1'b0;
    repeat (5) @(negedge clk);
    `CHK(fault_pin, 1'b0)
    `CHK(laser, 1'b1)
    $display("fault test done");
    // unsafe level stops the laser but raises no fault
    unsafe = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({laser, fault_pin}, 2'b00)
    unsafe = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(laser, 1'b1)
    rd_reg(8'h6f, rv);
    `CHK(rv, 8'h00)
    $display("unsafe and unmapped test done");
    // a reset stands for a power cycle and drops a latched fault
    fault = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(fault_pin, 1'b1)
    fault = 1'b0;
    srst = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({laser, oe, bwh, olost, rvalid}, 5'b01000)
    srst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({laser, fault_pin}, 2'b10)
    rd_reg(OMCS_CSB_ADDR, rv);
    `CHK(rv, 8'h00)
    $display("mid-run reset test done");
    stop_test();
  end
endmodule : omcs_ctrl_tb
`default_nettype wire
